// *** pmt_map.svh ***
// Register offsets, field positions and reset values of the match timer
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

// ==========================================
// Register byte offsets
`define PMT_OFF_FLAGS 12'h000
`define PMT_OFF_RUN   12'h004
`define PMT_OFF_TC    12'h008
`define PMT_OFF_PR    12'h00c
`define PMT_OFF_PC    12'h010
`define PMT_OFF_MCR   12'h014
`define PMT_OFF_MR0   12'h018
`define PMT_OFF_MR1   12'h01c
`define PMT_OFF_MR2   12'h020
`define PMT_OFF_MR3   12'h024
`define PMT_OFF_MASK  12'h040

// ==========================================
// Field positions
`define PMT_RUN_EN_BIT 0
`define PMT_CLR_BIT    1
`define PMT_MCR_IRQ    0
`define PMT_MCR_CLEAR  1
`define PMT_MCR_HALT   2
`define PMT_MCR_STRIDE 3
`define PMT_MCR_W      12
`define PMT_FLAG_W     4

// ==========================================
// Reset values
`define PMT_RST_WORD 32'h0000_0000
`define PMT_RST_MCR  12'h000
`define PMT_RST_FLAG 4'h0
`define PMT_ALL_ONES 32'hffff_ffff

`endif

// *** pmt_pkg.sv ***
// Types shared by the match timer and its bus
package pmt_pkg;

  // ==========================================
  // APB request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pmt_apb_rsp_t;

  // ==========================================
  // Register selector
  typedef enum logic [3:0] {
    sel_flags, sel_run, sel_tc, sel_pr, sel_pc, sel_mcr,
    sel_mr0, sel_mr1, sel_mr2, sel_mr3, sel_mask, sel_none
  } pmt_sel_t;

  // ==========================================
  // Complete state of the timer
  typedef struct packed {
    pmt_apb_rsp_t    rsp;
    logic            irq;
    logic            run_en;
    logic            clr;
    logic [31:0]     tc;
    logic [31:0]     pr;
    logic [31:0]     pc;
    logic [11:0]     match_action_control;
    logic [3:0][31:0] mr;
    logic [3:0]      flags;
    logic [3:0]      mask;
  } pmt_state_t;

endpackage

// *** pmt_timer.sv ***
// Prescaled 32-bit match timer with APB register access
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

// ==========================================
// Overview of operation
// - Run bit lets both counters advance
// - Clear bit zeroes counters while it is set
// - Main counter steps on prescale terminal count
// - Main counter wraps from all ones
// - Wrap sets no interrupt flag
// - Prescale limit register holds terminal value
// - Prescale counter steps every enabled clock
// - At limit: main steps, prescale returns zero
// - Limit N divides the clock by N+1
// - Interrupt enable bit at 3*channel
// - Clear enable bit at 3*channel+1
// - Halt enable bit at 3*channel+2 stops
// - Four match values compared every cycle
// - Match with interrupt enable bit set sets flag; write one clears

module pmt_timer
#(
  parameter int MATCH_CH = 4
)
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire pmt_pkg::pmt_apb_req_t apb_req,
  output var  pmt_pkg::pmt_apb_rsp_t apb_rsp,
  output var  logic                  irq
);
  import pmt_pkg::*;

  // ==========================================
  // Elaboration check
  // The control register layout has room for exactly four channels
  if (MATCH_CH != 4)
  begin : g_chk
    $error("pmt_timer supports exactly four match channels");
  end

  // ==========================================
  // Address decode
  function automatic pmt_sel_t pmt_dec(input logic [11:0] a);
    pmt_sel_t s;
    s = sel_none;
    if (a == `PMT_OFF_FLAGS)
      s = sel_flags;
    else if (a == `PMT_OFF_RUN)
      s = sel_run;
    else if (a == `PMT_OFF_TC)
      s = sel_tc;
    else if (a == `PMT_OFF_PR)
      s = sel_pr;
    else if (a == `PMT_OFF_PC)
      s = sel_pc;
    else if (a == `PMT_OFF_MCR)
      s = sel_mcr;
    else if (a == `PMT_OFF_MR0)
      s = sel_mr0;
    else if (a == `PMT_OFF_MR1)
      s = sel_mr1;
    else if (a == `PMT_OFF_MR2)
      s = sel_mr2;
    else if (a == `PMT_OFF_MR3)
      s = sel_mr3;
    else if (a == `PMT_OFF_MASK)
      s = sel_mask;
    return s;
  endfunction

  // ==========================================
  // State and working signals
  pmt_state_t st_ff;
  pmt_state_t nxt_st;
  pmt_sel_t   sel;
  logic       setup;
  logic       wr_any;
  logic       tick;
  logic [3:0] hit;
  logic [3:0] evt;
  logic [3:0] irq_set;
  logic       clr_any;
  logic       stop_any;
  logic [31:0] rd;

  // Outputs come straight from the state flops
  assign apb_rsp = st_ff.rsp;
  assign irq     = st_ff.irq;

  // ==========================================
  // Next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    sel    = pmt_dec(apb_req.paddr);
    setup  = apb_req.psel & ~apb_req.penable;
    // A write lands only at the access edge that sees pready high
    wr_any = apb_req.psel & apb_req.penable & st_ff.rsp.pready & apb_req.pwrite;

    // Terminal count of the prescaler; held off while clearing
    tick = st_ff.run_en & ~st_ff.clr & (st_ff.pc == st_ff.pr);

    // Match compare and per-channel actions
    clr_any  = 1'b0;
    stop_any = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      hit[i]     = (st_ff.tc == st_ff.mr[i]);
      // Actions fire on the edge the counter would leave the value
      evt[i]     = tick & hit[i];
      irq_set[i] = evt[i] & st_ff.match_action_control[`PMT_MCR_STRIDE*i+`PMT_MCR_IRQ];
      clr_any    = clr_any | (evt[i] & st_ff.match_action_control[`PMT_MCR_STRIDE*i+`PMT_MCR_CLEAR]);
      stop_any   = stop_any | (evt[i] & st_ff.match_action_control[`PMT_MCR_STRIDE*i+`PMT_MCR_HALT]);
    end

    // Counting: disabled counters simply keep their value
    if (st_ff.run_en & ~st_ff.clr)
    begin
      if (stop_any)
      begin
        // Halt leaves both counters where they stand
        nxt_st.run_en = 1'b0;
      end
      else if (tick)
      begin
        nxt_st.pc = `PMT_RST_WORD;
        // Plain add wraps to zero and touches no flag
        nxt_st.tc = clr_any ? `PMT_RST_WORD : st_ff.tc + 32'h0000_0001;
      end
      else
      begin
        nxt_st.pc = st_ff.pc + 32'h0000_0001;
      end
    end

    // Sticky flags: a new match wins over a clear in the same cycle
    nxt_st.flags = st_ff.flags | irq_set;
    if (wr_any && sel == sel_flags)
      nxt_st.flags = (st_ff.flags & ~apb_req.pwdata[`PMT_FLAG_W-1:0]) | irq_set;

    // Software writes; counter writes load directly
    if (wr_any)
    begin
      if (sel == sel_run)
      begin
        nxt_st.run_en = apb_req.pwdata[`PMT_RUN_EN_BIT];
        nxt_st.clr    = apb_req.pwdata[`PMT_CLR_BIT];
      end
      else if (sel == sel_tc)
        nxt_st.tc = apb_req.pwdata;
      else if (sel == sel_pr)
        nxt_st.pr = apb_req.pwdata;
      else if (sel == sel_pc)
        nxt_st.pc = apb_req.pwdata;
      else if (sel == sel_mcr)
        nxt_st.match_action_control = apb_req.pwdata[`PMT_MCR_W-1:0];
      else if (sel == sel_mr0)
        nxt_st.mr[0] = apb_req.pwdata;
      else if (sel == sel_mr1)
        nxt_st.mr[1] = apb_req.pwdata;
      else if (sel == sel_mr2)
        nxt_st.mr[2] = apb_req.pwdata;
      else if (sel == sel_mr3)
        nxt_st.mr[3] = apb_req.pwdata;
      else if (sel == sel_mask)
        nxt_st.mask = apb_req.pwdata[`PMT_FLAG_W-1:0];
    end

    // Clear bit overrides counting and counter loads from the edge it is written
    if (nxt_st.clr)
    begin
      nxt_st.tc = `PMT_RST_WORD;
      nxt_st.pc = `PMT_RST_WORD;
    end

    // Read mux; unused and reserved bits read as zero
    rd = 32'h0000_0000;
    if (sel == sel_flags)
      rd = {28'h000_0000, st_ff.flags};
    else if (sel == sel_run)
      rd = {30'h0000_0000, st_ff.clr, st_ff.run_en};
    else if (sel == sel_tc)
      rd = st_ff.tc;
    else if (sel == sel_pr)
      rd = st_ff.pr;
    else if (sel == sel_pc)
      rd = st_ff.pc;
    else if (sel == sel_mcr)
      rd = {20'h0_0000, st_ff.match_action_control};
    else if (sel == sel_mr0)
      rd = st_ff.mr[0];
    else if (sel == sel_mr1)
      rd = st_ff.mr[1];
    else if (sel == sel_mr2)
      rd = st_ff.mr[2];
    else if (sel == sel_mr3)
      rd = st_ff.mr[3];
    else if (sel == sel_mask)
      rd = {28'h000_0000, st_ff.mask};

    // One wait-free answer: ready rises for the access phase only
    nxt_st.rsp = '0;
    if (setup)
    begin
      nxt_st.rsp.pready  = 1'b1;
      nxt_st.rsp.pslverr = (sel == sel_none);
      nxt_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
    end

    // Level interrupt from unmasked sticky flags
    nxt_st.irq = |(nxt_st.flags & nxt_st.mask);
  end

  // ==========================================
  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ==========================================
  // Assertions
  a_clear_holds: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.clr |-> (st_ff.tc == 32'h0 && st_ff.pc == 32'h0))
    else $error("counters not zero while clear bit set");

  a_idle_holds: assert property (@(posedge clk) disable iff (!nrst)
    (!st_ff.run_en && !wr_any) |=> ($stable(st_ff.tc) && $stable(st_ff.pc)))
    else $error("disabled counters moved");

  a_sw_load: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_tc && !st_ff.clr && apb_req.pwdata[0]) |=> st_ff.tc[0])
    else $error("counter write did not load");

  a_prescale_step: assert property (@(posedge clk) disable iff (!nrst)
    (st_ff.run_en && !st_ff.clr && st_ff.pc != st_ff.pr && !wr_any)
    |=> st_ff.pc == $past(st_ff.pc) + 32'h1)
    else $error("prescale counter did not step");

  a_tick_step: assert property (@(posedge clk) disable iff (!nrst)
    (tick && evt == 4'h0 && !wr_any)
    |=> (st_ff.tc == $past(st_ff.tc) + 32'h1 && st_ff.pc == 32'h0))
    else $error("main counter did not step at terminal count");

  a_wrap_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (tick && st_ff.tc == `PMT_ALL_ONES && evt == 4'h0 && !wr_any)
    |=> (st_ff.tc == 32'h0 && $stable(st_ff.flags)))
    else $error("wrap failed or raised a flag");

  a_match_flag: assert property (@(posedge clk) disable iff (!nrst)
    (irq_set != 4'h0) |=> ((st_ff.flags & $past(irq_set)) == $past(irq_set)))
    else $error("match did not set its flag");

  a_match_clear: assert property (@(posedge clk) disable iff (!nrst)
    (clr_any && !stop_any && !wr_any) |=> st_ff.tc == 32'h0)
    else $error("match did not clear main counter");

  a_match_halt: assert property (@(posedge clk) disable iff (!nrst)
    (stop_any && !wr_any) |=> (!st_ff.run_en && $stable(st_ff.tc) ##1 $stable(st_ff.tc)))
    else $error("halt match did not stop the timer");

  a_flag_w1c: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_flags && apb_req.pwdata[0] && !irq_set[0]) |=> !st_ff.flags[0])
    else $error("write one did not clear flag");

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.irq == |(st_ff.flags & st_ff.mask))
    else $error("interrupt output disagrees with flags");

  a_apb_ready: assert property (@(posedge clk) disable iff (!nrst)
    (apb_req.psel && !apb_req.penable) |=> st_ff.rsp.pready ##1 !st_ff.rsp.pready)
    else $error("pready not a single access cycle");

  // ==========================================
  // Assertions on counting and the control bits
  // Counting antecedents exclude bus writes, since a write may load any counter
  a_run_advances: assert property (@(posedge clk) disable iff (!nrst)
    (st_ff.run_en && !st_ff.clr && !clr_any && !stop_any && !wr_any)
    |=> (st_ff.pc != $past(st_ff.pc) || st_ff.tc != $past(st_ff.tc)))
    else $error("enabled counters did not advance");

  a_clear_write: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_run && apb_req.pwdata[`PMT_CLR_BIT])
    |=> (st_ff.clr && st_ff.tc == 32'h0 && st_ff.pc == 32'h0))
    else $error("clear bit write did not zero the counters");

  a_clear_sticks: assert property (@(posedge clk) disable iff (!nrst)
    (st_ff.clr && !(wr_any && sel == sel_run)) |=> st_ff.clr)
    else $error("clear bit dropped without a write");

  a_tc_only_tick: assert property (@(posedge clk) disable iff (!nrst)
    (!tick && !wr_any) |=> $stable(st_ff.tc))
    else $error("main counter moved without terminal count");

  a_wrap_zero: assert property (@(posedge clk) disable iff (!nrst)
    (tick && st_ff.tc == `PMT_ALL_ONES && !clr_any && !stop_any && !wr_any)
    |=> st_ff.tc == 32'h0)
    else $error("main counter did not wrap to zero");

  a_flag_only_match: assert property (@(posedge clk) disable iff (!nrst)
    (irq_set == 4'h0) |=> ((st_ff.flags & ~$past(st_ff.flags)) == 4'h0))
    else $error("flag set without an enabled match");

  a_pr_load: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_pr) |=> st_ff.pr == $past(apb_req.pwdata))
    else $error("prescale limit write did not load");

  a_pr_keep: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_any && sel == sel_pr) |=> $stable(st_ff.pr))
    else $error("prescale limit changed without a write");

  a_tick_clears_pc: assert property (@(posedge clk) disable iff (!nrst)
    (tick && !stop_any && !wr_any) |=> st_ff.pc == 32'h0)
    else $error("prescale counter not zero after terminal count");

  // ==========================================
  // Assertions on the match channels
  // Channel 1 stands in for the interrupt enable bits, channel 3 for the flags: each bit layout is one shared stride
  a_mcr_keep: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_any && sel == sel_mcr) |=> $stable(st_ff.match_action_control))
    else $error("action control changed without a write");

  a_no_irq_bit: assert property (@(posedge clk) disable iff (!nrst)
    (evt[1] && !st_ff.match_action_control[`PMT_MCR_STRIDE+`PMT_MCR_IRQ] && !st_ff.flags[1])
    |=> !st_ff.flags[1])
    else $error("flag set with its interrupt enable off");

  a_stop_no_clear: assert property (@(posedge clk) disable iff (!nrst)
    (stop_any && clr_any && !wr_any) |=> $stable(st_ff.tc))
    else $error("clear-on-match overrode a halt");

  a_halt_pc: assert property (@(posedge clk) disable iff (!nrst)
    (stop_any && !wr_any) |=> ($stable(st_ff.pc) && !st_ff.run_en))
    else $error("halt match did not freeze the prescaler");

  a_mr_keep: assert property (@(posedge clk) disable iff (!nrst)
    !(wr_any && (sel == sel_mr0 || sel == sel_mr1 || sel == sel_mr2 || sel == sel_mr3))
    |=> $stable(st_ff.mr))
    else $error("match value changed without a write");

  a_flag_w0: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_flags && !apb_req.pwdata[3] && st_ff.flags[3])
    |=> st_ff.flags[3])
    else $error("writing zero cleared a flag");

  a_mask_gate: assert property (@(posedge clk) disable iff (!nrst)
    (st_ff.mask == 4'h0) |-> !st_ff.irq)
    else $error("interrupt raised with all channels masked");

  // ==========================================
  // Assertions on software loads and the bus answer
  // A load must win over counting, or software could never preset a phase
  a_tc_load: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_tc && !st_ff.clr)
    |=> st_ff.tc == $past(apb_req.pwdata))
    else $error("main counter write did not load");

  a_pc_load: assert property (@(posedge clk) disable iff (!nrst)
    (wr_any && sel == sel_pc && !st_ff.clr)
    |=> st_ff.pc == $past(apb_req.pwdata))
    else $error("prescale counter write did not load");

  a_bad_addr: assert property (@(posedge clk) disable iff (!nrst)
    (setup && sel == sel_none)
    |=> (st_ff.rsp.pslverr && st_ff.rsp.prdata == 32'h0))
    else $error("unmapped access not refused");

  a_answer_idle: assert property (@(posedge clk) disable iff (!nrst)
    !st_ff.rsp.pready |-> (st_ff.rsp.prdata == 32'h0 && !st_ff.rsp.pslverr))
    else $error("answer fields set outside the access cycle");

endmodule

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the prescaled match timer over APB
`timescale 1ns/1ps
`default_nettype none
`include "pmt_map.svh"

module tb_top;
  import pmt_pkg::*;

  // ==========================================
  // Signals and counters
  logic         clk;
  logic         nrst;
  pmt_apb_req_t req;
  pmt_apb_rsp_t rsp;
  logic         irq;
  logic [31:0]  rd;
  logic         er;
  int           n_mismatch;
  int           tests_run;

  pmt_timer #(.MATCH_CH(4)) uut
  (
    .clk     (clk),
    .nrst    (nrst),
    .apb_req (req),
    .apb_rsp (rsp),
    .irq     (irq)
  );

  // ==========================================
  // Clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Verdict in one place, for the tests and the watchdog alike
  task automatic end_sim;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      n_mismatch++;
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    // Any wait states are honoured; only the watchdog ends a hung wait
    while (rsp.pready !== 1'b1)
      @(posedge clk);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask

  // Irq is registered; look one step after the edge so its update has landed
  task automatic irq_is(input logic exp, input string msg);
    #1;
    chk({31'h0, irq}, {31'h0, exp}, msg);
  endtask

  // ==========================================
  // Watchdog, well beyond the fewer than a thousand cycles the tests need
  initial
  begin
    #2000000;
    n_mismatch++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    req  = '0;
    n_mismatch = 0;
    tests_run  = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, then direct load of every wide register
    for (int i = 0; i < 11; i++)
      rdc((i < 10) ? 12'(4 * i) : `PMT_OFF_MASK, 32'h0, "reset value");
    for (int i = 2; i < 10; i++)
    begin
      if (i != 5)
      begin
        wr(12'(4 * i), 32'ha5c3_0f00 + i);
        rdc(12'(4 * i), 32'ha5c3_0f00 + i, "load");
      end
    end
    wr(`PMT_OFF_MCR, 32'h0000_0fff);
    rdc(`PMT_OFF_MCR, 32'h0000_0fff, "action bits");
    wr(`PMT_OFF_MCR, 32'h0);
    // Unmapped address is refused
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1, "slave error");
    rdc(`PMT_OFF_MCR, 32'h0, "action bits cleared");
    chk({31'h0, er}, 32'h0, "no slave error");
    // Halt-on-match per channel with prescale limit 2: match at tc 5
    for (int i = 0; i < 4; i++)
    begin
      wr(`PMT_OFF_FLAGS, 32'hf);
      wr(`PMT_OFF_TC, 32'h0);
      wr(`PMT_OFF_PC, 32'h0);
      wr(`PMT_OFF_PR, 32'h2);
      wr(`PMT_OFF_MR0 + 12'(4 * i), 32'h5);
      wr(`PMT_OFF_MCR, 32'h5 << (3 * i));
      wr(`PMT_OFF_MASK, 32'h1 << i);
      wr(`PMT_OFF_RUN, 32'h1);
      repeat (17) @(posedge clk);
      irq_is(1'b0, "irq early");
      @(posedge clk);
      irq_is(1'b1, "irq on match");
      rdc(`PMT_OFF_RUN, 32'h0, "run after halt");
      rdc(`PMT_OFF_TC, 32'h5, "tc after halt");
      rdc(`PMT_OFF_PC, 32'h2, "pc after halt");
      rdc(`PMT_OFF_FLAGS, 32'h1 << i, "flag");
      wr(`PMT_OFF_MR0 + 12'(4 * i), 32'ha5c3_0000);
    end
    // Write zero keeps the flag, mask gates irq, write one clears
    wr(`PMT_OFF_FLAGS, 32'h0);
    rdc(`PMT_OFF_FLAGS, 32'h8, "w0 no effect");
    wr(`PMT_OFF_MASK, 32'h0);
    @(posedge clk);
    irq_is(1'b0, "masked");
    wr(`PMT_OFF_MASK, 32'h8);
    @(posedge clk);
    irq_is(1'b1, "unmasked");
    wr(`PMT_OFF_FLAGS, 32'h8);
    rdc(`PMT_OFF_FLAGS, 32'h0, "w1 clears");
    irq_is(1'b0, "irq cleared");
    // Stopped main counter holds its value
    wr(`PMT_OFF_TC, 32'h7);
    repeat (10) @(posedge clk);
    rdc(`PMT_OFF_TC, 32'h7, "hold stopped");
    // Clear bit zeroes and holds both counters even while running
    wr(`PMT_OFF_PC, 32'h1);
    wr(`PMT_OFF_RUN, 32'h3);
    rdc(`PMT_OFF_TC, 32'h0, "tc cleared");
    rdc(`PMT_OFF_PC, 32'h0, "pc cleared");
    wr(`PMT_OFF_RUN, 32'h0);
    // Wrap with limit 0: three counting edges from all ones minus one
    wr(`PMT_OFF_MCR, 32'h0);
    wr(`PMT_OFF_PR, 32'h0);
    wr(`PMT_OFF_TC, 32'hffff_fffe);
    wr(`PMT_OFF_RUN, 32'h1);
    wr(`PMT_OFF_RUN, 32'h0);
    rdc(`PMT_OFF_TC, 32'h1, "wrap");
    rdc(`PMT_OFF_FLAGS, 32'h0, "no wrap flag");
    // Clear-on-match on every channel keeps the main counter within 0..3
    for (int i = 0; i < 4; i++)
    begin
      wr(`PMT_OFF_FLAGS, 32'hf);
      wr(`PMT_OFF_TC, 32'h0);
      wr(`PMT_OFF_MR0 + 12'(4 * i), 32'h3);
      wr(`PMT_OFF_MCR, 32'h3 << (3 * i));
      wr(`PMT_OFF_RUN, 32'h1);
      repeat (40) @(posedge clk);
      wr(`PMT_OFF_RUN, 32'h0);
      apb(1'b0, `PMT_OFF_TC, 32'h0);
      chk({31'h0, rd <= 32'h3}, 32'h1, "clear on match");
      rdc(`PMT_OFF_FLAGS, 32'h1 << i, "match flag");
      wr(`PMT_OFF_MR0 + 12'(4 * i), 32'ha5c3_0000);
    end
    end_sim();
  end

endmodule

`default_nettype wire
